// ### ppsc_host.sv
// Host model issuing configuration cycles to the power register
`default_nettype none
module ppsc_host (
	input  wire logic        clock,
	output var  logic [7:0]  cfg_addr,
	output var  logic        cfg_wr,
	output var  logic        cfg_rd,
	output var  logic [3:0]  cfg_be,
	output var  logic [31:0] cfg_wdata,
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus before the first request
	initial begin
		cfg_addr  = 8'h00;
		cfg_wr    = 1'b0;
		cfg_rd    = 1'b0;
		cfg_be    = 4'h0;
		cfg_wdata = 32'h0;
	end

	// One write; released lines flip so stale values never match
	task automatic wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge clock);
		cfg_addr  = a;
		cfg_be    = be;
		cfg_wdata = d;
		cfg_wr    = 1'b1;
		@(negedge clock);
		cfg_wr    = 1'b0;
		cfg_addr  = ~a;
		cfg_wdata = ~d;
	endtask

	// One read; data only counts when the valid pulse is seen
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clock);
		cfg_addr = a;
		cfg_rd   = 1'b1;
		@(negedge clock);
		cfg_rd   = 1'b0;
		cfg_addr = ~a;
		d = (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hxxxxxxxx;
	endtask
endmodule
`default_nettype wire

// ### ppsc_pkg.sv
// Types shared by the power state control block
`default_nettype none
package ppsc_pkg;

	// Encoding of the two-bit power level field
	typedef enum logic [1:0] {
		LVL_D0    = 2'h0,
		LVL_D1    = 2'h1,
		LVL_D2    = 2'h2,
		LVL_D3HOT = 2'h3
	} ppsc_level_t;

	// Device power sequence, one-hot
	typedef enum logic [4:0] {
		S_D0_UNINIT = 5'h01,
		S_D0_INIT   = 5'h02,
		S_LOW       = 5'h04,
		S_D3HOT     = 5'h08,
		S_SOFT_RST  = 5'h10
	} ppsc_state_t;

	// Whole state of the control block
	typedef struct packed {
		logic        flag;
		logic        gate;
		logic        keep;
		logic        strap_done;
		logic [1:0]  level;
		ppsc_state_t fsm;
		logic [15:0] cnt;
		logic        int_reset;
		logic        cfg_lost;
		logic        d0i;
		logic [31:0] rdata;
		logic        rvalid;
	} ppsc_ctl_t;

	// State of the wake pin driver
	typedef struct packed {
		logic pin_n;
	} ppsc_gate_t;

endpackage
`default_nettype wire

// ### ppsc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PPSC_REGS_SVH
`define PPSC_REGS_SVH

`define PPSC_PMCS_OFS      8'h54
`define PPSC_FLAG_BIT      15
`define PPSC_GATE_BIT      8
`define PPSC_KEEP_BIT      3
`define PPSC_LVL_MSB       1
`define PPSC_LVL_LSB       0
`define PPSC_LVL_RESET     2'h0
`define PPSC_RD_MASK       32'h0000810b
`define PPSC_CLK_PERIOD_NS 100
`define PPSC_SRST_TIME_NS  1000
`define PPSC_SRST_CYCLES \
	((`PPSC_SRST_TIME_NS + `PPSC_CLK_PERIOD_NS - 1) / `PPSC_CLK_PERIOD_NS)

`endif

// ### ppsc_top.sv
// Power-management control and status register with D-state sequencing
`default_nettype none
`include "ppsc_regs.svh"
module ppsc_top #(
	parameter int SRST_CYCLES = `PPSC_SRST_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        hw_reset,
	input  wire logic        sw_reset,
	input  wire logic        pme_event,
	input  wire logic        keep_context_strap,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output var  logic [31:0] cfg_rdata,
	output var  logic        cfg_rvalid,
	output var  logic        wake_request_n,
	output var  logic [1:0]  power_level,
	output var  logic        internal_reset,
	output var  logic        d0_initialized,
	output var  logic        context_lost
);

	localparam logic [7:0]  PMCS_OFS  = `PPSC_PMCS_OFS;
	localparam logic [31:0] RD_MASK   = `PPSC_RD_MASK;
	localparam logic [1:0]  LVL_RESET = `PPSC_LVL_RESET;

	// Counter is 16 bits wide and needs at least one cycle
	if (SRST_CYCLES < 1 || SRST_CYCLES > 65535) begin : g_bad_srst
		$error("SRST_CYCLES out of range");
	end

	// Word decode; the low two address bits select bytes, not words
	function automatic logic cfg_hit(input logic [7:0] a);
		return a[7:2] == PMCS_OFS[7:2];
	endfunction

	// Register image; every reserved position is forced to zero
	function automatic logic [31:0] pack_reg(
		input logic       flag,
		input logic       gate,
		input logic       keep,
		input logic [1:0] level
	);
		logic [31:0] v;
		v = 32'h00000000;
		v[`PPSC_FLAG_BIT] = flag;
		v[`PPSC_GATE_BIT] = gate;
		v[`PPSC_KEEP_BIT] = keep;
		v[`PPSC_LVL_MSB:`PPSC_LVL_LSB] = level;
		return v & RD_MASK;
	endfunction

	ppsc_pkg::ppsc_ctl_t s;
	ppsc_pkg::ppsc_ctl_t next_s;

	logic       wr_hit;
	logic       flag_clr;
	logic       gate_wr;
	logic       lvl_wr;
	logic [1:0] lvl_req;

	// Write strobes per field, qualified by the byte lanes
	assign wr_hit   = cfg_wr && cfg_hit(cfg_addr);
	assign flag_clr = wr_hit && cfg_be[1] && cfg_wdata[`PPSC_FLAG_BIT];
	assign gate_wr  = wr_hit && cfg_be[1];
	assign lvl_wr   = wr_hit && cfg_be[0];
	assign lvl_req  = cfg_wdata[`PPSC_LVL_MSB:`PPSC_LVL_LSB];

	// Next state of the whole block
	always_comb begin
		next_s = s;
		next_s.rvalid = 1'b0;
		next_s.cfg_lost = 1'b0;

		// Strap caught once after power-up; bit 3 is never host-writable
		if (!s.strap_done) begin
			next_s.keep = keep_context_strap;
			next_s.strap_done = 1'b1;
		end

		// Write-one clears, a same-cycle event still sets
		if (flag_clr) begin
			next_s.flag = 1'b0;
		end
		if (pme_event) begin
			next_s.flag = 1'b1;
		end

		// Gate is plain read-write; resets below leave it alone
		if (gate_wr) begin
			next_s.gate = cfg_wdata[`PPSC_GATE_BIT];
		end

		// Power level sequencing
		case (s.fsm)
			ppsc_pkg::S_SOFT_RST: begin
				// Level writes ignored until the internal reset ends
				if (s.cnt == 16'h0000) begin
					next_s.fsm = ppsc_pkg::S_D0_UNINIT;
					next_s.int_reset = 1'b0;
				end else begin
					next_s.cnt = s.cnt - 16'h0001;
				end
			end
			ppsc_pkg::S_D3HOT: begin
				if (lvl_wr) begin
					next_s.level = lvl_req;
					if (lvl_req == ppsc_pkg::LVL_D0) begin
						if (s.keep) begin
							next_s.fsm = ppsc_pkg::S_D0_INIT;
						end else begin
							next_s.fsm = ppsc_pkg::S_SOFT_RST;
							next_s.int_reset = 1'b1;
							next_s.cfg_lost = 1'b1;
							next_s.cnt = 16'(SRST_CYCLES - 1);
						end
					end else if (lvl_req != ppsc_pkg::LVL_D3HOT) begin
						next_s.fsm = ppsc_pkg::S_LOW;
					end
				end
			end
			ppsc_pkg::S_D0_UNINIT,
			ppsc_pkg::S_D0_INIT,
			ppsc_pkg::S_LOW: begin
				if (lvl_wr) begin
					next_s.level = lvl_req;
					case (lvl_req)
						ppsc_pkg::LVL_D0: begin
							// Driver writing D0 marks setup complete
							next_s.fsm = ppsc_pkg::S_D0_INIT;
						end
						ppsc_pkg::LVL_D3HOT: begin
							next_s.fsm = ppsc_pkg::S_D3HOT;
						end
						default: begin
							next_s.fsm = ppsc_pkg::S_LOW;
						end
					endcase
				end
			end
			default: begin
				next_s.fsm = ppsc_pkg::S_D0_UNINIT;
			end
		endcase

		// Software reset drops driver setup but keeps wake context
		if (sw_reset && s.fsm == ppsc_pkg::S_D0_INIT) begin
			next_s.fsm = ppsc_pkg::S_D0_UNINIT;
			next_s.cfg_lost = 1'b1;
		end

		// Bus reset wins over everything; flag and gate are untouched
		if (hw_reset) begin
			next_s.fsm = ppsc_pkg::S_D0_UNINIT;
			next_s.level = LVL_RESET;
			next_s.int_reset = 1'b0;
			next_s.cnt = 16'h0000;
			next_s.cfg_lost = (s.fsm != ppsc_pkg::S_D0_UNINIT);
		end

		next_s.d0i = (next_s.fsm == ppsc_pkg::S_D0_INIT);

		// Reads give the current image; other offsets read zero
		if (cfg_rd) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = cfg_hit(cfg_addr) ?
				pack_reg(s.flag, s.gate, s.keep, s.level) : 32'h00000000;
		end
	end

	// Only power-up reset clears flag and gate
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '{
				flag:       1'b0,
				gate:       1'b0,
				keep:       1'b0,
				strap_done: 1'b0,
				level:      LVL_RESET,
				fsm:        ppsc_pkg::S_D0_UNINIT,
				cnt:        16'h0000,
				int_reset:  1'b0,
				cfg_lost:   1'b0,
				d0i:        1'b0,
				rdata:      32'h00000000,
				rvalid:     1'b0
			};
		end else begin
			s <= next_s;
		end
	end

	// Pin driver fed from next values so it tracks the register exactly
	ppsc_wake_gate u_wake (
		.clock          (clock),
		.rst            (rst),
		.next_flag      (next_s.flag),
		.next_gate      (next_s.gate),
		.wake_request_n (wake_request_n)
	);

	assign cfg_rdata      = s.rdata;
	assign cfg_rvalid     = s.rvalid;
	assign power_level    = s.level;
	assign internal_reset = s.int_reset;
	assign d0_initialized = s.d0i;
	assign context_lost   = s.cfg_lost;

	// Wake pin checks
	a_pin_asserts: assert property (@(posedge clock) disable iff (rst)
		s.flag && s.gate |-> !wake_request_n)
		else $error("wake pin not driven with flag and gate set");
	a_pin_needs_gate: assert property (@(posedge clock) disable iff (rst)
		!s.gate |-> wake_request_n)
		else $error("wake pin driven with gate clear");
	a_pin_release: assert property (@(posedge clock) disable iff (rst)
		$fell(s.flag) |-> wake_request_n)
		else $error("wake pin held after flag cleared");

	// Flag and gate checks
	a_event_sets_flag: assert property (@(posedge clock) disable iff (rst)
		pme_event |=> s.flag ##1 (s.flag || $past(flag_clr)))
		else $error("power event did not set flag");
	a_w1c_clears: assert property (@(posedge clock) disable iff (rst)
		flag_clr && !pme_event |=> !s.flag)
		else $error("write one did not clear flag");
	a_flag_survives: assert property (@(posedge clock) disable iff (rst)
		(hw_reset || sw_reset) && !flag_clr && !pme_event |=> $stable(s.flag))
		else $error("flag changed on reset");
	a_gate_survives: assert property (@(posedge clock) disable iff (rst)
		(hw_reset || sw_reset) && !gate_wr |=> $stable(s.gate))
		else $error("gate changed on reset");

	// Sequencing checks, then the reserved-bit read check
	a_keep_no_reset: assert property (@(posedge clock) disable iff (rst)
		s.fsm == ppsc_pkg::S_D3HOT && lvl_wr && lvl_req == 2'h0 && s.keep
		&& !hw_reset |=> d0_initialized && !internal_reset)
		else $error("keep path lost context");
	a_soft_reset: assert property (@(posedge clock) disable iff (rst)
		s.fsm == ppsc_pkg::S_D3HOT && lvl_wr && lvl_req == 2'h0 && !s.keep
		&& !hw_reset |=> internal_reset && context_lost ##1 !context_lost)
		else $error("soft reset path wrong");
	a_bus_reset: assert property (@(posedge clock) disable iff (rst)
		hw_reset |=> power_level == 2'h0 && !d0_initialized
		&& !internal_reset)
		else $error("bus reset did not leave D0 uninitialized");
	a_level_write: assert property (@(posedge clock) disable iff (rst)
		lvl_wr && !hw_reset && s.fsm != ppsc_pkg::S_SOFT_RST
		|=> power_level == $past(lvl_req))
		else $error("level field did not take write");
	a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
		cfg_rvalid |-> (cfg_rdata & ~RD_MASK) == 32'h00000000)
		else $error("reserved bits read nonzero");

	// Register image and bus checks
	a_rvalid_pulse: assert property (@(posedge clock) disable iff (rst)
		cfg_rd |=> cfg_rvalid)
		else $error("read not answered");
	a_lvl_readback: assert property (@(posedge clock) disable iff (rst)
		cfg_rd && cfg_hit(cfg_addr)
		|=> cfg_rdata[`PPSC_LVL_MSB:`PPSC_LVL_LSB] == $past(s.level))
		else $error("level read back wrong");
	a_flag_readback: assert property (@(posedge clock) disable iff (rst)
		cfg_rd && cfg_hit(cfg_addr)
		|=> cfg_rdata[`PPSC_FLAG_BIT] == $past(s.flag))
		else $error("flag read back wrong");
	a_other_zero: assert property (@(posedge clock) disable iff (rst)
		cfg_rd && !cfg_hit(cfg_addr) |=> cfg_rdata == 32'h00000000)
		else $error("other offset read nonzero");
	a_gate_write: assert property (@(posedge clock) disable iff (rst)
		gate_wr |=> s.gate == $past(cfg_wdata[`PPSC_GATE_BIT]))
		else $error("gate did not take write");
	a_keep_readonly: assert property (@(posedge clock) disable iff (rst)
		s.strap_done |=> $stable(s.keep))
		else $error("keep bit changed after strap");

	// Further wake and sequencing checks
	a_flag_holds: assert property (@(posedge clock) disable iff (rst)
		s.flag && !pme_event && !flag_clr |=> s.flag)
		else $error("flag lost without write one");
	a_gate_drop: assert property (@(posedge clock) disable iff (rst)
		$fell(s.gate) |-> wake_request_n)
		else $error("wake pin held after gate cleared");
	a_srst_ends: assert property (@(posedge clock) disable iff (rst)
		$fell(internal_reset) |-> !d0_initialized)
		else $error("soft reset did not end uninitialized");
	a_d3_bus_lost: assert property (@(posedge clock) disable iff (rst)
		hw_reset && s.fsm == ppsc_pkg::S_D3HOT |=> context_lost)
		else $error("bus reset from D3hot kept context");

	// Main scenarios
	c_wake_asserted: cover property (@(posedge clock) disable iff (rst)
		$fell(wake_request_n));
	c_keep_path: cover property (@(posedge clock) disable iff (rst)
		s.fsm == ppsc_pkg::S_D3HOT ##1 s.fsm == ppsc_pkg::S_D0_INIT);
	c_soft_reset_done: cover property (@(posedge clock) disable iff (rst)
		$fell(internal_reset));
	c_bus_reset_d3: cover property (@(posedge clock) disable iff (rst)
		s.fsm == ppsc_pkg::S_D3HOT && hw_reset);
	c_sw_reset_init: cover property (@(posedge clock) disable iff (rst)
		sw_reset && s.fsm == ppsc_pkg::S_D0_INIT);

endmodule
`default_nettype wire

// ### ppsc_wake_gate.sv
// Wake request pin driver, registered from the next flag and gate values
`default_nettype none
module ppsc_wake_gate (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic next_flag,
	input  wire logic next_gate,
	output var  logic wake_request_n
);

	ppsc_pkg::ppsc_gate_t s;
	ppsc_pkg::ppsc_gate_t next_s;

	// Built from next values so the pin moves with the flag, not after
	always_comb begin
		next_s = s;
		next_s.pin_n = !(next_flag && next_gate);
	end

	// Pin released while power-up reset is held
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '{pin_n: 1'b1};
		end else begin
			s <= next_s;
		end
	end

	assign wake_request_n = s.pin_n;

endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the power state control block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SRST = 2;
	logic        clock = 1'b1;
	logic        rst = 1'b1;
	logic        hw_reset = 1'b0;
	logic        sw_reset = 1'b0;
	logic        pme_event = 1'b0;
	logic        strap = 1'b0;
	logic [7:0]  cfg_addr;
	logic        cfg_wr;
	logic        cfg_rd;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata;
	logic [31:0] cfg_rdata;
	logic        cfg_rvalid;
	logic        wake_n;
	logic [1:0]  level;
	logic        irst;
	logic        d0i;
	logic        lost;
	logic [31:0] r;
	int          fails = 0;
	int          tests_run = 0;

	// 100 ns clock
	always #50 clock = ~clock;

	ppsc_top #(.SRST_CYCLES(SRST)) u_dut (
		.clock(clock), .rst(rst), .hw_reset(hw_reset),
		.sw_reset(sw_reset), .pme_event(pme_event),
		.keep_context_strap(strap), .cfg_addr(cfg_addr),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid), .wake_request_n(wake_n),
		.power_level(level), .internal_reset(irst),
		.d0_initialized(d0i), .context_lost(lost));

	ppsc_host u_host (
		.clock(clock), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Power-up reset held two cycles, strap settled beforehand
	task automatic power_up(input logic s);
		@(negedge clock);
		rst   = 1'b1;
		strap = s;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		repeat (2) @(negedge clock);
	endtask

	// One-cycle pulse on an event input, expressed by selector
	task automatic pulse(input int which);
		@(negedge clock);
		if (which == 0) pme_event = 1'b1;
		else if (which == 1) hw_reset = 1'b1;
		else sw_reset = 1'b1;
		@(negedge clock);
		pme_event = 1'b0;
		hw_reset  = 1'b0;
		sw_reset  = 1'b0;
	endtask

	// Main sequence
	initial begin
		power_up(1'b0);
		u_host.rd(8'h54, r);
		check(r, 32'h0);
		u_host.rd(8'h50, r);
		check(r, 32'h0);
		u_host.wr(8'h54, 4'hf, 32'hffff_fffe);
		u_host.rd(8'h54, r);
		check(r, 32'h0000_0102);
		for (int i = 1; i < 4; i++) begin
			u_host.wr(8'h54, 4'h1, 32'(i));
			check({30'h0, level}, 32'(i));
		end
		pulse(0);
		check({31'h0, wake_n}, 32'h0);
		pulse(1);
		u_host.rd(8'h54, r);
		check(r, 32'h0000_8100);
		check({31'h0, d0i}, 32'h0);
		pulse(2);
		u_host.rd(8'h54, r);
		check(r, 32'h0000_8100);
		check({31'h0, wake_n}, 32'h0);
		u_host.wr(8'h54, 4'h2, 32'h0000_8100);
		check({31'h0, wake_n}, 32'h1);
		u_host.rd(8'h54, r);
		check(r, 32'h0000_0100);
		u_host.wr(8'h54, 4'h2, 32'h0);
		pulse(0);
		check({31'h0, wake_n}, 32'h1);
		u_host.wr(8'h54, 4'h2, 32'h0000_0100);
		check({31'h0, wake_n}, 32'h0);
		u_host.wr(8'h54, 4'h1, 32'h3);
		u_host.wr(8'h54, 4'h1, 32'h0);
		check({30'h0, irst, lost}, 32'h3);
		@(negedge clock);
		check({31'h0, lost}, 32'h0);
		repeat (SRST + 2) @(negedge clock);
		check({30'h0, irst, d0i}, 32'h0);
		// Power-up must drop the pending flag and the gate
		power_up(1'b1);
		u_host.rd(8'h54, r);
		check(r, 32'h0000_0008);
		check({31'h0, wake_n}, 32'h1);
		u_host.wr(8'h54, 4'h1, 32'h3);
		u_host.wr(8'h54, 4'h1, 32'h0);
		check({30'h0, irst, d0i}, 32'h1);
		// Software reset from D0 initialized drops setup only
		pulse(2);
		check({30'h0, lost, d0i}, 32'h2);
		u_host.rd(8'h54, r);
		check(r, 32'h0000_0008);
		stop_test();
	end

	// Watchdog: the sequence needs well under 200 cycles
	initial begin
		#100000;
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire
